// ### design/dicc_pkg.sv
/*
 Constants, register map and carrier types for the interface configuration block.
 Assumes a 250 MHz core clock and an APB master with 32-bit data.
*/
`default_nettype none
package dicc_pkg;
	localparam logic [7:0]  ADDR_CTRL = 8'h00, ADDR_CENTER = 8'h04, ADDR_RANGE = 8'h08;
	localparam logic [7:0]  ADDR_REACQ = 8'h0c, ADDR_EXTREF = 8'h10, ADDR_BUFSZ = 8'h14;
	localparam logic [7:0]  ADDR_COMMIT = 8'h18, ADDR_STATUS = 8'h1c, ADDR_REPORT = 8'h20;
	localparam int          CTRL_BER = 0, CTRL_RS = 4, CTRL_TXSRC = 8, CTRL_PHASE = 12;
	localparam int          CTRL_BUFCLK = 16, CTRL_UNITS = 20, CTRL_DNI = 21;
	localparam int          ST_REJ = 8, ST_ACQ = 4, ST_FAULT = 0, RP_DEPTH = 8;
	localparam logic [1:0]  RS_OFF = 2'h0, RS_ON = 2'h1, RS_BYPASS = 2'h2;
	localparam logic [1:0]  SRC_INT = 2'h0, SRC_EXT = 2'h1, SRC_TERR = 2'h2;
	localparam logic [1:0]  PH_NORM = 2'h0, PH_INV = 2'h1, PH_AUTO = 2'h2;
	localparam logic [2:0]  BCLK_EXT = 3'h2, BCLK_MAX = 3'h4, BER_MAX = 3'h6;
	localparam logic [3:0]  BER_EXP_OFS = 4'h2;
	localparam logic signed [16:0] CENTER_MIN = -17'sd30000, CENTER_MAX = 17'sd30000;
	localparam logic [15:0] RANGE_MAX = 16'hea60;
	localparam logic [9:0]  REACQ_MAX = 10'h3e7;
	localparam logic [13:0] EXTREF_MIN = 14'h0008, EXTREF_MAX = 14'h2710, BCLK_EXT_MIN = 14'h0020;
	localparam logic [17:0] MS_MAX = 18'h00063, DNI_MS_MAX = 18'h00020;
	localparam logic [17:0] BITS_MIN = 18'h00020, BITS_MAX = 18'h3ffff;
	localparam logic [18:0] BITS_TOP = 19'h40000;
	localparam int unsigned CLK_HZ = 250000000, ONE_SEC_S = 1;
	localparam int unsigned SEC_CYCLES_DEF = ONE_SEC_S * CLK_HZ;
	localparam logic [17:0] BUFSZ_RST = 18'h00180;
	localparam logic [13:0] EXTREF_RST = 14'h0608;
	typedef enum logic [2:0] {
		ACQ_NORMAL = 3'b001, ACQ_DIRECTED = 3'b010, ACQ_REACQ = 3'b100
	} dicc_acq_e;
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [7:0]        paddr;
		logic [31:0]       pwdata;
	} dicc_apb_s;
	typedef struct packed {
		logic [2:0]        ber_thr;
		logic [1:0]        rs_mode;
		logic [1:0]        tx_src;
		logic [1:0]        tx_phase;
		logic [2:0]        buf_clk;
		logic              buf_ms;
		logic              dni;
		logic signed [16:0] center;
		logic [15:0]       range;
		logic [9:0]        reacq;
		logic [13:0]       extref;
		logic [17:0]       bufsz;
	} dicc_cfg_s;
	localparam dicc_cfg_s CFG_RST = '{3'h0, RS_OFF, SRC_TERR, PH_AUTO, 3'h0, 1'b0, 1'b0,
		17'sd0, RANGE_MAX, 10'h000, EXTREF_RST, BUFSZ_RST};
endpackage
`default_nettype wire

// ### design/dicc_top.sv
/*
 Interface configuration and supervision block: APB register file with shadow
 settings, commit logic, acquisition sweep control, outer decoder mode, clock
 selection and buffer depth. Assumes the pins LOCK_I, EXTERNAL_REFERENCE_CLOCK_OK_I, TERR_CLK_OK_I
 and TX_PHASE_ERR_I are asynchronous; all other inputs share CORE_CLK_I.
*/
// The APB interface to the registers and the register addresses were chosen for this implementation.
`default_nettype none
module dicc_top #(
	parameter int unsigned SEC_CYCLES = dicc_pkg::SEC_CYCLES_DEF
) (
	input  wire logic              CORE_CLK_I,
	input  wire logic              RESET_I,
	input  wire logic              CE_I,
	input  wire dicc_pkg::dicc_apb_s APB_I,
	output logic [31:0]            APB_PRDATA_O,
	output logic                   APB_PREADY_O,
	output logic                   APB_PSLVERR_O,
	input  wire logic              LOCK_I,
	input  wire logic              EXTERNAL_REFERENCE_CLOCK_OK_I,
	input  wire logic              TERR_CLK_OK_I,
	input  wire logic              TX_PHASE_ERR_I,
	input  wire logic              RS_SUPPORT_I,
	input  wire logic              RX_RETUNE_I,
	input  wire logic [3:0]        INNER_BER_I,
	input  wire logic [3:0]        OUTER_BER_I,
	input  wire logic [13:0]       RX_RATE_KBPS_I,
	output logic                   RX_FAULT_O,
	output logic [3:0]             BER_REPORT_O,
	output logic                   RS_DECODER_EN_O,
	output logic                   RS_CORRECT_EN_O,
	output logic signed [16:0]     SWEEP_CENTER_O,
	output logic [15:0]            SWEEP_SPAN_O,
	output logic                   REACQ_ACTIVE_O,
	output logic [1:0]             TX_CLK_SEL_O,
	output logic                   TX_CLK_INV_O,
	output logic [2:0]             BUF_CLK_SEL_O,
	output logic [13:0]            EXTERNAL_REFERENCE_CLOCK_KHZ_O,
	output logic                   BUF_BYPASS_O,
	output logic [21:0]            BUF_DEPTH_O
);
	import dicc_pkg::*;

	dicc_cfg_s   sh, next_sh, act, next_act;
	logic [7:0]  rej, next_rej;
	logic [31:0] prdata, next_prdata;
	logic        pready, next_pready, pslverr, next_pslverr;
	logic [3:0]  sync1, sync2;
	logic        lock_q, perr_q, pick_inv, next_pick_inv;
	dicc_acq_e   state, next_state;
	logic [27:0] sec_cnt, next_sec_cnt;
	logic [9:0]  reacq_cnt, next_reacq_cnt;
	logic        wr_en, commit, mapped;
	logic [3:0]  ber_rep;
	logic        lock_s, ext_ok_s, terr_ok_s, perr_s;

	// Two-flop synchronisers; only sync2 is read by logic
	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end else if (CE_I) begin
			sync1 <= {TX_PHASE_ERR_I, TERR_CLK_OK_I, EXTERNAL_REFERENCE_CLOCK_OK_I, LOCK_I};
			sync2 <= sync1;
		end
	end
	assign lock_s    = sync2[0];
	assign ext_ok_s  = sync2[1];
	assign terr_ok_s = sync2[2];
	assign perr_s    = sync2[3];

	// Bus decode; a write lands only on the completing access edge
	assign wr_en  = APB_I.psel && APB_I.penable && pready && APB_I.pwrite;
	assign commit = wr_en && (APB_I.paddr == ADDR_COMMIT);
	always_comb begin
		case (APB_I.paddr)
			ADDR_CTRL, ADDR_CENTER, ADDR_RANGE, ADDR_REACQ, ADDR_EXTREF,
			ADDR_BUFSZ, ADDR_COMMIT, ADDR_STATUS, ADDR_REPORT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Read data is prepared in the setup cycle so every bus output is a flop
	always_comb begin
		next_pready  = APB_I.psel && !APB_I.penable && !pready;
		next_pslverr = APB_I.psel && !APB_I.penable && !mapped;
		next_prdata  = 32'h0;
		if (APB_I.psel && !APB_I.penable && !APB_I.pwrite) begin
			case (APB_I.paddr)
				ADDR_CTRL: begin
					next_prdata[CTRL_BER +: 3]    = sh.ber_thr;
					next_prdata[CTRL_RS +: 2]     = sh.rs_mode;
					next_prdata[CTRL_TXSRC +: 2]  = sh.tx_src;
					next_prdata[CTRL_PHASE +: 2]  = sh.tx_phase;
					next_prdata[CTRL_BUFCLK +: 3] = sh.buf_clk;
					next_prdata[CTRL_UNITS]       = sh.buf_ms;
					next_prdata[CTRL_DNI]         = sh.dni;
				end
				ADDR_CENTER: next_prdata = 32'(sh.center);
				ADDR_RANGE:  next_prdata[15:0] = sh.range;
				ADDR_REACQ:  next_prdata[9:0] = sh.reacq;
				ADDR_EXTREF: next_prdata[13:0] = sh.extref;
				ADDR_BUFSZ:  next_prdata[17:0] = sh.bufsz;
				ADDR_STATUS: begin
					next_prdata[ST_FAULT]     = RX_FAULT_O;
					next_prdata[ST_ACQ +: 3]  = state;
					next_prdata[ST_REJ +: 8]  = rej;
				end
				ADDR_REPORT: begin
					next_prdata[3:0]            = BER_REPORT_O;
					next_prdata[RP_DEPTH +: 22] = BUF_DEPTH_O;
				end
				default: next_prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else if (CE_I) begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// Shadow settings: software edits these freely, logic never sees them yet
	always_comb begin
		next_sh = sh;
		if (wr_en) begin
			case (APB_I.paddr)
				ADDR_CTRL: begin
					next_sh.ber_thr  = APB_I.pwdata[CTRL_BER +: 3];
					next_sh.rs_mode  = APB_I.pwdata[CTRL_RS +: 2];
					next_sh.tx_src   = APB_I.pwdata[CTRL_TXSRC +: 2];
					next_sh.tx_phase = APB_I.pwdata[CTRL_PHASE +: 2];
					next_sh.buf_clk  = APB_I.pwdata[CTRL_BUFCLK +: 3];
					next_sh.buf_ms   = APB_I.pwdata[CTRL_UNITS];
					next_sh.dni      = APB_I.pwdata[CTRL_DNI];
				end
				ADDR_CENTER: next_sh.center = $signed(APB_I.pwdata[16:0]);
				ADDR_RANGE:  next_sh.range  = APB_I.pwdata[15:0];
				ADDR_REACQ:  next_sh.reacq  = APB_I.pwdata[9:0];
				ADDR_EXTREF: next_sh.extref = APB_I.pwdata[13:0];
				ADDR_BUFSZ:  next_sh.bufsz  = APB_I.pwdata[17:0];
				default:     next_sh = sh;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			sh <= CFG_RST;
		end else if (CE_I) begin
			sh <= next_sh;
		end
	end

	// Commit: each field except tx_src is checked; an out-of-range field keeps its old value
	// and raises its reject flag, so one bad entry cannot corrupt the rest
	always_comb begin
		next_act = act;
		next_rej = rej;
		if (wr_en && APB_I.paddr == ADDR_STATUS) begin
			next_rej = rej & ~APB_I.pwdata[ST_REJ +: 8];
		end
		if (commit) begin
			if (sh.ber_thr <= BER_MAX) next_act.ber_thr = sh.ber_thr;
			else next_rej[7] = 1'b1;
			if (sh.rs_mode == RS_ON && !RS_SUPPORT_I) begin
				next_rej[0] = 1'b1;
			end else if (sh.rs_mode <= RS_BYPASS) begin
				next_act.rs_mode = sh.rs_mode;
			end else begin
				next_rej[0] = 1'b1;
			end
			if (sh.center >= CENTER_MIN && sh.center <= CENTER_MAX) begin
				next_act.center = sh.center;
			end else begin
				next_rej[1] = 1'b1;
			end
			if (sh.range <= RANGE_MAX) next_act.range = sh.range;
			else next_rej[2] = 1'b1;
			if (sh.reacq <= REACQ_MAX) next_act.reacq = sh.reacq;
			else next_rej[3] = 1'b1;
			if (sh.extref >= EXTREF_MIN && sh.extref <= EXTREF_MAX) begin
				next_act.extref = sh.extref;
			end else begin
				next_rej[4] = 1'b1;
			end
			// Reference as buffer clock needs the 32 kHz floor
			if (sh.buf_clk <= BCLK_MAX && !(sh.buf_clk == BCLK_EXT
				&& next_act.extref < BCLK_EXT_MIN)) begin
				next_act.buf_clk = sh.buf_clk;
			end else begin
				next_rej[5] = 1'b1;
			end
			// Mode, units and depth move together; a refused depth keeps all three,
			// so drop-insert can never sit on a depth beyond its limit
			if (sh.dni) begin
				if (sh.bufsz != 18'h0 && sh.bufsz <= DNI_MS_MAX) begin
					next_act.dni    = 1'b1;
					next_act.buf_ms = 1'b1;
					next_act.bufsz  = sh.bufsz;
				end else begin
					next_rej[6] = 1'b1;
				end
			end else if (sh.buf_ms && sh.bufsz <= MS_MAX) begin
				next_act.dni    = 1'b0;
				next_act.buf_ms = 1'b1;
				next_act.bufsz  = sh.bufsz;
			end else if (!sh.buf_ms && sh.bufsz >= BITS_MIN && sh.bufsz[3:0] == 4'h0) begin
				next_act.dni    = 1'b0;
				next_act.buf_ms = 1'b0;
				next_act.bufsz  = sh.bufsz;
			end else begin
				next_rej[6] = 1'b1;
			end
			next_act.tx_src = sh.tx_src;
			if (sh.tx_phase <= PH_AUTO) next_act.tx_phase = sh.tx_phase;
			else next_rej[7] = 1'b1;
		end
		// Retune wins over a same-cycle commit of decoder on
		if (RX_RETUNE_I) next_act.rs_mode = RS_OFF;
	end

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			act <= CFG_RST;
			rej <= 8'h00;
		end else if (CE_I) begin
			act <= next_act;
			rej <= next_rej;
		end
	end

	// Acquisition sweep: lock loss with a nonzero timer enters narrow sweep
	always_comb begin
		dicc_acq_e base;
		base = (act.range == RANGE_MAX) ? ACQ_NORMAL : ACQ_DIRECTED;
		next_state     = state;
		next_sec_cnt   = sec_cnt;
		next_reacq_cnt = reacq_cnt;
		case (state)
			ACQ_NORMAL, ACQ_DIRECTED: begin
				next_state   = base;
				next_sec_cnt = 28'h0;
				if (lock_q && !lock_s && act.reacq != 10'h0) begin
					next_state     = ACQ_REACQ;
					next_reacq_cnt = act.reacq;
				end
			end
			ACQ_REACQ: begin
				if (sec_cnt == 28'(SEC_CYCLES - 1)) begin
					next_sec_cnt   = 28'h0;
					next_reacq_cnt = reacq_cnt - 10'h1;
				end else begin
					next_sec_cnt = sec_cnt + 28'h1;
				end
				if (lock_s || reacq_cnt == 10'h0) next_state = base;
			end
			default: next_state = ACQ_NORMAL;
		endcase
	end

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			state     <= ACQ_NORMAL;
			sec_cnt   <= 28'h0;
			reacq_cnt <= 10'h0;
			lock_q    <= 1'b0;
		end else if (CE_I) begin
			state     <= next_state;
			sec_cnt   <= next_sec_cnt;
			reacq_cnt <= next_reacq_cnt;
			lock_q    <= lock_s;
		end
	end

	// Auto phase flips its choice on each rising phase-error indication
	always_comb begin
		next_pick_inv = pick_inv;
		if (act.tx_phase == PH_AUTO && perr_s && !perr_q) next_pick_inv = !pick_inv;
	end

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			pick_inv <= 1'b0;
			perr_q   <= 1'b0;
		end else if (CE_I) begin
			pick_inv <= next_pick_inv;
			perr_q   <= perr_s;
		end
	end

	// Reported error ratio source follows the decoder mode
	assign ber_rep = (act.rs_mode == RS_ON) ? OUTER_BER_I : INNER_BER_I;

	// Registered outputs; a lost source drops the transmit clock select back to the internal clock
	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			RX_FAULT_O      <= 1'b0;
			BER_REPORT_O    <= 4'h0;
			RS_DECODER_EN_O <= 1'b0;
			RS_CORRECT_EN_O <= 1'b0;
			SWEEP_CENTER_O  <= 17'sd0;
			SWEEP_SPAN_O    <= RANGE_MAX;
			REACQ_ACTIVE_O  <= 1'b0;
			TX_CLK_SEL_O    <= SRC_INT;
			TX_CLK_INV_O    <= 1'b0;
			BUF_CLK_SEL_O   <= 3'h0;
			EXTERNAL_REFERENCE_CLOCK_KHZ_O   <= EXTREF_RST;
			BUF_BYPASS_O    <= 1'b0;
			BUF_DEPTH_O     <= 22'h0;
		end else if (CE_I) begin
			// Exponent form: ratio 1e-n arrives as n, so smaller n is worse
			RX_FAULT_O <= act.ber_thr != 3'h0
				&& ber_rep < {1'b0, act.ber_thr} + BER_EXP_OFS;
			BER_REPORT_O    <= ber_rep;
			RS_DECODER_EN_O <= act.rs_mode != RS_OFF;
			RS_CORRECT_EN_O <= act.rs_mode == RS_ON;
			SWEEP_CENTER_O  <= act.center;
			case (state)
				ACQ_REACQ:    SWEEP_SPAN_O <= act.range / 16'd10;
				ACQ_DIRECTED: SWEEP_SPAN_O <= act.range;
				default:      SWEEP_SPAN_O <= RANGE_MAX;
			endcase
			REACQ_ACTIVE_O <= state == ACQ_REACQ;
			if ((act.tx_src == SRC_EXT && ext_ok_s) || (act.tx_src == SRC_TERR && terr_ok_s)) begin
				TX_CLK_SEL_O <= act.tx_src;
			end else begin
				TX_CLK_SEL_O <= SRC_INT;
			end
			TX_CLK_INV_O  <= (act.tx_phase == PH_INV)
				|| (act.tx_phase == PH_AUTO && pick_inv);
			BUF_CLK_SEL_O <= act.buf_clk;
			EXTERNAL_REFERENCE_CLOCK_KHZ_O <= act.extref;
			BUF_BYPASS_O  <= act.buf_ms && act.bufsz == 18'h0;
			// Rate in kbit/s equals bits per millisecond
			if (act.buf_ms) begin
				// Widen before the product; at 14 bits fast rates would wrap
				BUF_DEPTH_O <= 22'(act.bufsz[6:0]) * 22'(RX_RATE_KBPS_I);
			end else begin
				BUF_DEPTH_O <= 22'(act.bufsz);
			end
		end
	end

	assign APB_PRDATA_O  = prdata;
	assign APB_PREADY_O  = pready;
	assign APB_PSLVERR_O = pslverr;

	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RESET_I);

	fault_raise_a: assert property (CE_I && act.ber_thr == 3'h1 && ber_rep < 4'h3
		|=> RX_FAULT_O) else $error("fault not raised");
	center_range_a: assert property (act.center >= CENTER_MIN && act.center <= CENTER_MAX)
		else $error("centre out of range");
	// State follows the active range one edge later
	normal_mode_a: assert property (state == ACQ_DIRECTED |-> $past(act.range) != RANGE_MAX)
		else $error("directed at full width");
	narrow_span_a: assert property (CE_I && state == ACQ_REACQ
		|=> SWEEP_SPAN_O == $past(act.range) / 16'd10) else $error("bad narrow span");
	reacq_limit_a: assert property (act.reacq <= REACQ_MAX && reacq_cnt <= REACQ_MAX)
		else $error("timer beyond limit");
	correct_on_a: assert property (CE_I && act.rs_mode == RS_ON
		|=> RS_CORRECT_EN_O && RS_DECODER_EN_O) else $error("correction off");
	bypass_path_a: assert property (CE_I && act.rs_mode == RS_BYPASS
		|=> !RS_CORRECT_EN_O && RS_DECODER_EN_O) else $error("bypass wrong");
	rs_reject_a: assert property (CE_I && commit && sh.rs_mode == RS_ON && !RS_SUPPORT_I
		|=> rej[0] && act.rs_mode == $past(act.rs_mode) || act.rs_mode == RS_OFF)
		else $error("unsupported on accepted");
	retune_off_a: assert property (CE_I && RX_RETUNE_I |=> act.rs_mode == RS_OFF)
		else $error("retune kept decoder");
	extref_range_a: assert property (act.extref >= EXTREF_MIN && act.extref <= EXTREF_MAX)
		else $error("reference out of range");
	dni_units_a: assert property (act.dni |-> act.buf_ms && act.bufsz <= DNI_MS_MAX)
		else $error("drop-insert depth wrong");
endmodule
`default_nettype wire

// ### testbench/dicc_dte_model.sv
/*
 Behavioural terrestrial equipment on the far side of the data interface.
 Assumes it shares the core clock; its pins reach the block's synchronisers.
*/
`default_nettype none
module dicc_dte_model (
	input  wire logic clk_i,
	input  wire logic ext_on_i,
	input  wire logic terr_on_i,
	input  wire logic slip_i,
	output var logic  ext_ok_o = 1'b0,
	output var logic  terr_ok_o = 1'b0,
	output var logic  phase_err_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] hold = 3'h0;
	// Reference is always an integer multiple locked to the sent data
	always @(posedge clk_i) begin
		ext_ok_o <= ext_on_i;
		terr_ok_o <= terr_on_i;
	end
	// A slip lasts five cycles so the block's two-flop synchroniser cannot miss it
	always @(posedge clk_i) begin
		hold <= slip_i ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
		phase_err_o <= slip_i || hold != 3'h0;
	end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
/*
 Self-checking bench: APB master tasks and one task per scenario.
 Assumes the block answers each access with pready in the first access cycle.
*/
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import dicc_pkg::*;
	logic clk, rst, lock, slip, want_ext, want_terr, rs_sup, retune, ext_ok, terr_ok, ph_err;
	logic ce;
	logic [3:0] inner, outer;
	logic [13:0] rate;
	dicc_apb_s apb;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, serr, fault, dec_en, cor_en, reacq, inv, bypass;
	logic [3:0] ber_rep;
	logic signed [16:0] center;
	logic [15:0] span;
	logic [1:0] tx_sel;
	logic [2:0] buf_sel;
	logic [13:0] ext_khz;
	logic [21:0] depth;
	int mismatches, cmp_count;
	dicc_top #(.SEC_CYCLES(20)) dut_u (.CORE_CLK_I(clk), .RESET_I(rst), .CE_I(ce),
		.APB_I(apb), .APB_PRDATA_O(prdata), .APB_PREADY_O(pready), .APB_PSLVERR_O(pslverr),
		.LOCK_I(lock), .EXTERNAL_REFERENCE_CLOCK_OK_I(ext_ok), .TERR_CLK_OK_I(terr_ok), .TX_PHASE_ERR_I(ph_err),
		.RS_SUPPORT_I(rs_sup), .RX_RETUNE_I(retune), .INNER_BER_I(inner), .OUTER_BER_I(outer),
		.RX_RATE_KBPS_I(rate), .RX_FAULT_O(fault), .BER_REPORT_O(ber_rep),
		.RS_DECODER_EN_O(dec_en), .RS_CORRECT_EN_O(cor_en), .SWEEP_CENTER_O(center),
		.SWEEP_SPAN_O(span), .REACQ_ACTIVE_O(reacq), .TX_CLK_SEL_O(tx_sel),
		.TX_CLK_INV_O(inv), .BUF_CLK_SEL_O(buf_sel), .EXTERNAL_REFERENCE_CLOCK_KHZ_O(ext_khz),
		.BUF_BYPASS_O(bypass), .BUF_DEPTH_O(depth));
	dicc_dte_model dte_u (.clk_i(clk), .ext_on_i(want_ext), .terr_on_i(want_terr),
		.slip_i(slip), .ext_ok_o(ext_ok), .terr_ok_o(terr_ok), .phase_err_o(ph_err));
	// Free-running core clock, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One idle edge first, so a release and a new setup never share a time step
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		apb <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		apb.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rdat = prdata;
		serr = pslverr;
		apb <= '0;
		if (n >= 16) begin
			mismatches++;
			$display("[FAIL] pready expected 1 seen 0");
			finish_test();
		end
	endtask
	task automatic commit;
		bus(1'b1, ADDR_COMMIT, 32'h0);
		step(2);
	endtask
	// Read sticky rejects, then clear them by writing ones
	task automatic rej(input logic [7:0] e);
		bus(1'b0, ADDR_STATUS, 32'h0);
		`CHK("rejects", e, rdat[15:8])
		bus(1'b1, ADDR_STATUS, 32'h0000ff00);
	endtask
	// Bad value must be refused with its flag; good value then commits cleanly
	task automatic tryv(input logic [7:0] a, input logic [31:0] bad, good, input logic [7:0] f);
		bus(1'b1, a, bad);
		commit();
		rej(f);
		bus(1'b1, a, good);
		commit();
		rej(8'h00);
	endtask
	task automatic t_reset;
		bus(1'b0, ADDR_CTRL, 32'h0);
		`CHK("ctrl", 32'h00002200, rdat)
		bus(1'b0, ADDR_STATUS, 32'h0);
		`CHK("acq", 3'b001, rdat[6:4])
		`CHK("span", 16'hea60, span)
		`CHK("txsel", SRC_TERR, tx_sel)
		bus(1'b0, 8'h24, 32'h0);
		`CHK("unmapped", 33'h100000000, {serr, rdat})
		$display("test reset done");
	endtask
	task automatic t_ber;
		inner <= 4'h1;
		step(2);
		`CHK("fault off", 1'b0, fault)
		tryv(ADDR_CTRL, 32'h2207, 32'h2200, 8'h80);
		for (int t = 1; t <= 6; t++) begin
			bus(1'b1, ADDR_CTRL, 32'h2200 | 32'(t));
			commit();
			inner <= 4'(t + 1);
			step(2);
			`CHK("fault", 1'b1, fault)
			inner <= 4'(t + 2);
			step(2);
			`CHK("no fault", 1'b0, fault)
		end
		bus(1'b1, ADDR_CTRL, 32'h2200);
		commit();
		$display("test ber done");
	endtask
	task automatic t_decoder;
		inner <= 4'h5;
		outer <= 4'h9;
		rs_sup <= 1'b0;
		tryv(ADDR_CTRL, 32'h2210, 32'h2200, 8'h01);
		`CHK("dec refused", 1'b0, dec_en)
		rs_sup <= 1'b1;
		bus(1'b1, ADDR_CTRL, 32'h2210);
		commit();
		`CHK("on", 3'h3, {dec_en, cor_en})
		`CHK("outer rep", 4'h9, ber_rep)
		bus(1'b1, ADDR_CTRL, 32'h2220);
		commit();
		`CHK("bypass", 3'h2, {dec_en, cor_en})
		`CHK("inner rep", 4'h5, ber_rep)
		bus(1'b1, ADDR_CTRL, 32'h2210);
		commit();
		@(posedge clk);
		retune <= 1'b1;
		@(posedge clk);
		retune <= 1'b0;
		step(2);
		`CHK("retune", 3'h0, {dec_en, cor_en})
		bus(1'b1, ADDR_CTRL, 32'h2200);
		commit();
		// Clock enable low must freeze the reported ratio
		ce <= 1'b0;
		inner <= 4'h3;
		step(3);
		`CHK("frozen", 4'h5, ber_rep)
		ce <= 1'b1;
		step(2);
		`CHK("thawed", 4'h3, ber_rep)
		inner <= 4'h5;
		$display("test decoder done");
	endtask
	task automatic t_sweep;
		tryv(ADDR_CENTER, 32'd30001, 32'hffff8ad0, 8'h02);
		`CHK("center", -17'sd30000, center)
		tryv(ADDR_RANGE, 32'd60001, 32'd1000, 8'h04);
		`CHK("span", 16'd1000, span)
		bus(1'b0, ADDR_STATUS, 32'h0);
		`CHK("directed", 3'b010, rdat[6:4])
		tryv(ADDR_REACQ, 32'd1000, 32'd2, 8'h08);
		lock <= 1'b0;
		step(6);
		`CHK("reacq", 17'h10064, {reacq, span})
		step(10);
		`CHK("reacq hold", 1'b1, reacq)
		step(60);
		`CHK("reacq end", 17'h003e8, {reacq, span})
		lock <= 1'b1;
		// Full width again returns to normal acquisition
		bus(1'b1, ADDR_RANGE, 32'd60000);
		commit();
		`CHK("full span", 16'hea60, span)
		bus(1'b0, ADDR_STATUS, 32'h0);
		`CHK("normal", 3'b001, rdat[6:4])
		$display("test sweep done");
	endtask
	task automatic t_txclk;
		bus(1'b1, ADDR_CTRL, 32'h2100);
		commit();
		`CHK("ext src", SRC_EXT, tx_sel)
		want_ext <= 1'b0;
		step(8);
		`CHK("fallback", SRC_INT, tx_sel)
		want_ext <= 1'b1;
		tryv(ADDR_CTRL, 32'h3200, 32'h1200, 8'h80);
		`CHK("inv", 1'b1, inv)
		bus(1'b1, ADDR_CTRL, 32'h0200);
		commit();
		`CHK("norm", 1'b0, inv)
		bus(1'b1, ADDR_CTRL, 32'h2200);
		commit();
		`CHK("auto", 1'b0, inv)
		slip <= 1'b1;
		@(posedge clk);
		slip <= 1'b0;
		step(8);
		`CHK("auto flip", 1'b1, inv)
		$display("test txclk done");
	endtask
	task automatic t_refs;
		tryv(ADDR_EXTREF, 32'd7, 32'd8, 8'h10);
		`CHK("ref min", 14'd8, ext_khz)
		tryv(ADDR_EXTREF, 32'd10001, 32'd16, 8'h10);
		tryv(ADDR_CTRL, 32'h22200, 32'h2200, 8'h20);
		tryv(ADDR_EXTREF, 32'd10001, 32'd10000, 8'h10);
		`CHK("ref max", 14'd10000, ext_khz)
		tryv(ADDR_CTRL, 32'h52200, 32'h2200, 8'h20);
		for (int b = 0; b < 5; b++) begin
			bus(1'b1, ADDR_CTRL, 32'h2200 | (32'(b) << 16));
			commit();
			`CHK("bufclk", 3'(b), buf_sel)
		end
		$display("test refs done");
	endtask
	task automatic t_buffer;
		bus(1'b1, ADDR_BUFSZ, 32'd0);
		bus(1'b1, ADDR_CTRL, 32'h102200);
		commit();
		`CHK("bypass", 1'b1, bypass)
		tryv(ADDR_BUFSZ, 32'd100, 32'd5, 8'h40);
		`CHK("ms depth", 23'd320, {bypass, depth})
		rate <= 14'd10000;
		step(2);
		`CHK("fast depth", 22'd50000, depth)
		rate <= 14'd64;
		step(2);
		bus(1'b1, ADDR_CTRL, 32'h202200);
		tryv(ADDR_BUFSZ, 32'd33, 32'd32, 8'h40);
		`CHK("dni depth", 22'd2048, depth)
		bus(1'b1, ADDR_CTRL, 32'h2200);
		tryv(ADDR_BUFSZ, 32'd392, 32'd400, 8'h40);
		`CHK("bit depth", 22'd400, depth)
		tryv(ADDR_BUFSZ, 32'd16, 32'd32, 8'h40);
		$display("test buffer done");
	endtask
	// Main sequence
	initial begin
		mismatches = 0;
		cmp_count = 0;
		rst = 1'b1;
		apb = '0;
		lock = 1'b1;
		slip = 1'b0;
		want_ext = 1'b1;
		want_terr = 1'b1;
		rs_sup = 1'b0;
		retune = 1'b0;
		inner = 4'h9;
		outer = 4'h9;
		rate = 14'd64;
		ce = 1'b1;
		step(8);
		rst <= 1'b0;
		step(6);
		t_reset();
		t_ber();
		t_decoder();
		t_sweep();
		t_txclk();
		t_refs();
		t_buffer();
		finish_test();
	end
endmodule
`default_nettype wire
